// ---- pkg/pwm_params.svh ----
// Register offsets, field positions and reset values of the match PWM block
`ifndef PWM_PARAMS_SVH
`define PWM_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define PWM_OFS_IRQ_STATUS   8'h00
`define PWM_OFS_IRQ_CLEAR    8'h04
`define PWM_OFS_IRQ_ENABLE   8'h08
`define PWM_OFS_CONTROL      8'h0c
`define PWM_OFS_COUNT        8'h10
`define PWM_OFS_PRESCALE     8'h14
`define PWM_OFS_PRESCALE_CNT 8'h18
`define PWM_OFS_COUNT_CTRL   8'h1c
`define PWM_OFS_MATCH_CTRL   8'h20
`define PWM_OFS_PWM_CTRL     8'h24
`define PWM_OFS_RELEASE      8'h28
`define PWM_OFS_MATCH_BASE   8'h40

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PWM_CTRL_RUN_BIT     0
`define PWM_CTRL_RESET_BIT   1
`define PWM_CTRL_PWM_BIT     3
`define PWM_CCTRL_SRC_LSB    0
`define PWM_CCTRL_CAPSEL_BIT 2
`define PWM_MCTRL_IRQ        0
`define PWM_MCTRL_RESET      1
`define PWM_MCTRL_STOP       2
`define PWM_MCTRL_WIDTH      3
`define PWM_PCTRL_DOUBLE_LSB 0
`define PWM_PCTRL_ENABLE_LSB 8

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PWM_RST_WORD         32'h0000_0000

`endif

// ---- pkg/pwm_pkg.sv ----
// Types shared by the match PWM block: bus carriers and enumerations
package pwm_pkg;

    // Classic Wishbone request from the master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } wb_req_s;

    // Wishbone answer of the slave
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wb_rsp_s;

    // Source that advances the prescaler
    typedef enum logic [1:0] {
        SRC_TIMER = 2'b00,
        SRC_RISE  = 2'b01,
        SRC_FALL  = 2'b10,
        SRC_BOTH  = 2'b11
    } count_src_e;

    // Bus slave state, Gray along idle -> ack -> idle
    typedef enum logic {
        BUS_IDLE = 1'b0,
        BUS_ACK  = 1'b1
    } bus_state_e;

endpackage : pwm_pkg

// ---- hdl/pwm_tick_gen.sv ----
// Prescaler and count source selection producing the counter tick
`timescale 1ns/1ps
`default_nettype none
`include "pwm_params.svh"

module pwm_tick_gen
    import pwm_pkg::*;
#(
    parameter int PRE_W = 32
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             run_i,
    input  wire logic             clear_i,
    input  wire count_src_e       src_i,
    input  wire logic             cap_sel_i,
    input  wire logic [1:0]       cap_i,
    input  wire logic [PRE_W-1:0] limit_i,
    output logic                  tick_o,
    output logic [PRE_W-1:0]      pre_count_o
);

    logic             cap_prev_reg;
    logic             cap_now;
    logic             src_event;
    logic [PRE_W-1:0] pre_reg;

    // Edge history of the chosen capture input
    assign cap_now = cap_i[cap_sel_i];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cap_prev_reg <= 1'b0;
        end else begin
            cap_prev_reg <= cap_now;
        end
    end

    // Clock or capture transitions feed the prescaler
    always_comb begin
        case (src_i)
            SRC_TIMER: src_event = 1'b1;                       // R01
            SRC_RISE:  src_event = cap_now & ~cap_prev_reg;    // R01
            SRC_FALL:  src_event = ~cap_now & cap_prev_reg;    // R01
            SRC_BOTH:  src_event = cap_now ^ cap_prev_reg;     // R01
            default:   src_event = 1'b0;
        endcase
    end

    // Prescaler wraps at its limit; the wrap is the counter tick
    always_ff @(posedge clk_i) begin
        if (rst_i || clear_i) begin
            pre_reg <= '0;
        end else if (run_i && src_event) begin
            // A limit lowered below the running count must not stall the tick
            if (pre_reg >= limit_i) begin
                pre_reg <= '0;
            end else begin
                pre_reg <= pre_reg + 1'b1;                     // R12
            end
        end
    end

    assign tick_o      = run_i & ~clear_i & src_event & (pre_reg >= limit_i);
    assign pre_count_o = pre_reg;

endmodule : pwm_tick_gen
`default_nettype wire

// ---- hdl/multi_channel_match_pwm.sv ----
// Match based PWM timer with Wishbone registers, seven matches and six outputs
// Function
// R01: Counter advances from the clock or from transitions of a chosen capture input.
// R02: Seven match registers serve six single-edge, three double-edge or mixed outputs.
// R03: Match zero sets the period by returning the counter to zero.
// R04: Each single-edge output uses one own match for its falling edge.
// R05: Single-edge outputs rise at each cycle start unless held constantly low.
// R06: Each double-edge output uses two matches, one rising and one falling.
// R07: Double edges may sit anywhere; order decides a positive or negative pulse.
// R08: All outputs share the repetition rate set by match zero.
// R09: Period and width are any whole number of ticks, full width compare.
// R10: Each match may continue, stop or reset the counter, optionally interrupting.
// R11: Software releases new match values; they apply at the cycle boundary.
// R12: Without PWM mode the block is a plain timer with prescaler.
// R13: A match event occurs when the counter equals a match on a tick.
// R14: Match flags stay set until cleared; interrupt is high while enabled flag set.
//
// The register offsets and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_params.svh"

module multi_channel_match_pwm
    import pwm_pkg::*;
#(
    parameter int NUM_MATCH = 7,
    parameter int CNT_W     = 32
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire wb_req_s              wb_req_i,
    output var  wb_rsp_s              wb_rsp_o,
    input  wire logic [1:0]           cap_i,
    output logic [NUM_MATCH-1:1]      pwm_o,
    output logic                      irq_o
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    bus_state_e                      state_reg;
    logic [31:0]                     rdata_reg;
    logic [31:0]                     rd_next;
    logic                            bus_take;
    logic                            wr_en;
    logic [7:0]                      adr;
    logic [7:0]                      mofs;
    logic                            in_match;
    logic [2:0]                      midx;
    logic                            run_reg;
    logic                            cnt_reset_reg;
    logic                            pwm_mode_reg;
    logic [CNT_W-1:0]                count_reg;
    logic [CNT_W-1:0]                prescale_reg;
    logic [CNT_W-1:0]                pre_count;
    count_src_e                      src_reg;
    logic                            cap_sel_reg;
    logic [NUM_MATCH*3-1:0]          mctrl_reg;
    logic [NUM_MATCH-1:0]            double_reg;
    logic [NUM_MATCH-1:0]            out_en_reg;
    logic [NUM_MATCH-1:0]            release_reg;
    logic [NUM_MATCH-1:0][CNT_W-1:0] match_wr_reg;
    logic [NUM_MATCH-1:0][CNT_W-1:0] match_act_reg;
    logic [NUM_MATCH-1:0]            irq_status_reg;
    logic [NUM_MATCH-1:0]            irq_en_reg;
    logic [NUM_MATCH-1:1]            pwm_reg;
    logic [NUM_MATCH-1:0]            match_hit;
    logic [NUM_MATCH-1:0]            hit_reset;
    logic [NUM_MATCH-1:0]            hit_stop;
    logic [NUM_MATCH-1:0]            hit_irq;
    logic                            tick;
    logic                            any_reset;
    logic                            any_stop;
    logic                            wr_ctrl;
    logic                            wr_count;
    logic                            cycle_start;

    // Byte lane merge for writes honouring sel
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                          input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = dat[b*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    // ------------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------------
    // One request is taken in idle, answered one cycle later, then idle again
    assign adr      = wb_req_i.adr;
    assign bus_take = wb_req_i.cyc & wb_req_i.stb & (state_reg == BUS_IDLE);
    // Writes land at the ack edge, while the master still holds its request
    assign wr_en    = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & (state_reg == BUS_ACK);
    assign mofs     = adr - `PWM_OFS_MATCH_BASE;
    assign midx     = mofs[4:2];
    assign in_match = (adr >= `PWM_OFS_MATCH_BASE) && (mofs[7:2] < 6'(NUM_MATCH));
    assign wr_ctrl  = wr_en && (adr == `PWM_OFS_CONTROL);
    assign wr_count = wr_en && (adr == `PWM_OFS_COUNT);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= BUS_IDLE;
        end else begin
            case (state_reg)
                BUS_IDLE: state_reg <= bus_take ? BUS_ACK : BUS_IDLE;
                BUS_ACK:  state_reg <= BUS_IDLE;
                default:  state_reg <= BUS_IDLE;
            endcase
        end
    end

    // Read view; unmapped and write-only offsets read as zero
    always_comb begin
        rd_next = `PWM_RST_WORD;
        case (adr)
            `PWM_OFS_IRQ_STATUS:   rd_next = 32'(irq_status_reg);
            `PWM_OFS_IRQ_ENABLE:   rd_next = 32'(irq_en_reg);
            `PWM_OFS_CONTROL: begin
                rd_next[`PWM_CTRL_RUN_BIT]   = run_reg;
                rd_next[`PWM_CTRL_RESET_BIT] = cnt_reset_reg;
                rd_next[`PWM_CTRL_PWM_BIT]   = pwm_mode_reg;
            end
            `PWM_OFS_COUNT:        rd_next = 32'(count_reg);
            `PWM_OFS_PRESCALE:     rd_next = 32'(prescale_reg);
            `PWM_OFS_PRESCALE_CNT: rd_next = 32'(pre_count);
            `PWM_OFS_COUNT_CTRL: begin
                rd_next[`PWM_CCTRL_SRC_LSB +: 2]  = src_reg;
                rd_next[`PWM_CCTRL_CAPSEL_BIT]    = cap_sel_reg;
            end
            `PWM_OFS_MATCH_CTRL:   rd_next = 32'(mctrl_reg);
            `PWM_OFS_PWM_CTRL: begin
                rd_next[`PWM_PCTRL_DOUBLE_LSB +: NUM_MATCH] = double_reg;
                rd_next[`PWM_PCTRL_ENABLE_LSB +: NUM_MATCH] = out_en_reg;
            end
            `PWM_OFS_RELEASE:      rd_next = 32'(release_reg);
            default: begin
                if (in_match) begin
                    rd_next = 32'(match_wr_reg[midx]);
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_reg <= `PWM_RST_WORD;
        end else if (bus_take) begin
            rdata_reg <= wb_req_i.we ? `PWM_RST_WORD : rd_next;
        end
    end

    assign wb_rsp_o.ack = (state_reg == BUS_ACK);
    assign wb_rsp_o.dat = rdata_reg;

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    // Stop on match wins over a software run write in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_reg       <= 1'b0;
            cnt_reset_reg <= 1'b0;
            pwm_mode_reg  <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                run_reg       <= wb_req_i.dat[`PWM_CTRL_RUN_BIT] & wb_req_i.sel[0];
                cnt_reset_reg <= wb_req_i.dat[`PWM_CTRL_RESET_BIT] & wb_req_i.sel[0];
                pwm_mode_reg  <= wb_req_i.dat[`PWM_CTRL_PWM_BIT] & wb_req_i.sel[0];
            end
            if (any_stop) begin
                run_reg <= 1'b0;                                  // R10
            end
        end
    end

    // Plain configuration words
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prescale_reg <= '0;
            src_reg      <= SRC_TIMER;
            cap_sel_reg  <= 1'b0;
            mctrl_reg    <= '0;
            double_reg   <= '0;
            out_en_reg   <= '0;
            irq_en_reg   <= '0;
        end else if (wr_en) begin
            case (adr)
                `PWM_OFS_PRESCALE:
                    prescale_reg <= CNT_W'(merge(32'(prescale_reg), wb_req_i.dat, wb_req_i.sel));
                `PWM_OFS_COUNT_CTRL: begin
                    src_reg     <= count_src_e'(wb_req_i.dat[`PWM_CCTRL_SRC_LSB +: 2]);
                    cap_sel_reg <= wb_req_i.dat[`PWM_CCTRL_CAPSEL_BIT];
                end
                `PWM_OFS_MATCH_CTRL:
                    mctrl_reg <= (NUM_MATCH*3)'(merge(32'(mctrl_reg), wb_req_i.dat,
                                                      wb_req_i.sel));
                `PWM_OFS_PWM_CTRL: begin
                    double_reg <= wb_req_i.dat[`PWM_PCTRL_DOUBLE_LSB +: NUM_MATCH];
                    out_en_reg <= wb_req_i.dat[`PWM_PCTRL_ENABLE_LSB +: NUM_MATCH];
                end
                `PWM_OFS_IRQ_ENABLE:
                    irq_en_reg <= wb_req_i.dat[NUM_MATCH-1:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Prescaler and counter
    // ------------------------------------------------------------------
    pwm_tick_gen #(
        .PRE_W (CNT_W)
    ) u_tick (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .run_i       (run_reg),
        .clear_i     (cnt_reset_reg | wr_count),
        .src_i       (src_reg),
        .cap_sel_i   (cap_sel_reg),
        .cap_i       (cap_i),
        .limit_i     (prescale_reg),
        .tick_o      (tick),
        .pre_count_o (pre_count)
    );

    // Match compare, one per match register over the full counter width
    for (genvar i = 0; i < NUM_MATCH; i++) begin : g_match                  // R02
        assign match_hit[i] = tick & (count_reg == match_act_reg[i]);     // R13 R09
        assign hit_irq[i]   = match_hit[i] & mctrl_reg[i*3 + `PWM_MCTRL_IRQ];
        assign hit_stop[i]  = match_hit[i] & mctrl_reg[i*3 + `PWM_MCTRL_STOP];
        assign hit_reset[i] = match_hit[i] & (mctrl_reg[i*3 + `PWM_MCTRL_RESET]
                              | ((i == 0) & pwm_mode_reg));                // R03 R10
    end

    assign cycle_start = pwm_mode_reg & match_hit[0];                      // R08
    assign any_reset   = |hit_reset;
    assign any_stop    = |hit_stop;

    // Reset wins over stop, stop holds the count where it matched
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_reg <= '0;
        end else if (wr_count) begin
            count_reg <= CNT_W'(merge(32'(count_reg), wb_req_i.dat, wb_req_i.sel));
        end else if (cnt_reset_reg) begin
            count_reg <= '0;
        end else if (tick) begin
            if (any_reset) begin
                count_reg <= '0;                                          // R03 R10
            end else if (!any_stop) begin
                count_reg <= count_reg + 1'b1;                            // R01 R12
            end
        end
    end

    // ------------------------------------------------------------------
    // Match values and release
    // ------------------------------------------------------------------
    // Software writes land in a holding copy; the compare copy follows it in timer mode
    // and in PWM mode only changes at a cycle boundary so a half-updated pair never makes a stray pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            match_wr_reg  <= '0;
            match_act_reg <= '0;
            release_reg   <= '0;
        end else begin
            for (int i = 0; i < NUM_MATCH; i++) begin
                if (wr_en && in_match && (midx == 3'(i))) begin
                    match_wr_reg[i] <= CNT_W'(merge(32'(match_wr_reg[i]), wb_req_i.dat,
                                                    wb_req_i.sel));
                end
                if (!pwm_mode_reg) begin
                    match_act_reg[i] <= match_wr_reg[i];                  // R12
                end else if (cycle_start && release_reg[i]) begin
                    match_act_reg[i] <= match_wr_reg[i];                  // R11
                end
                if (wr_en && (adr == `PWM_OFS_RELEASE) && wb_req_i.dat[i]) begin
                    release_reg[i] <= 1'b1;                               // R11
                end else if (cycle_start) begin
                    release_reg[i] <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // PWM outputs
    // ------------------------------------------------------------------
    // Output 1 is always single edge; a fall coinciding with a rise wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwm_reg <= '0;
        end else begin
            for (int n = 1; n < NUM_MATCH; n++) begin
                if (!pwm_mode_reg || !out_en_reg[n]) begin
                    pwm_reg[n] <= 1'b0;
                end else if (match_hit[n]) begin
                    pwm_reg[n] <= 1'b0;                                   // R04 R06
                end else if (double_reg[n] && (n > 1)) begin
                    if (match_hit[n-1]) begin
                        pwm_reg[n] <= 1'b1;                               // R06 R07
                    end
                end else if (cycle_start && (match_act_reg[n] != '0)) begin
                    pwm_reg[n] <= 1'b1;                                   // R05 R08
                end
            end
        end
    end

    assign pwm_o = pwm_reg;

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    // A match arriving with its clear keeps the flag set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_status_reg <= '0;
        end else begin
            irq_status_reg <= (irq_status_reg
                               & ~((wr_en && (adr == `PWM_OFS_IRQ_CLEAR))
                                   ? wb_req_i.dat[NUM_MATCH-1:0] : '0))
                              | hit_irq;                                  // R14 R10
        end
    end

    assign irq_o = |(irq_status_reg & irq_en_reg);                        // R14

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_bus_ack_once: assert property (bus_take |=> wb_rsp_o.ack ##1 !wb_rsp_o.ack)
        else $error("ack not a single cycle after request");
    a_cycle_wrap: assert property (cycle_start && !wr_count |=> count_reg == '0) // R03
        else $error("counter did not wrap at cycle match");
    a_count_step: assert property (tick && !any_reset && !any_stop && !wr_count
                                   |=> count_reg == $past(count_reg) + 1'b1) // R01
        else $error("counter did not advance on tick");
    a_stop_match: assert property (any_stop |=> !run_reg)                   // R10
        else $error("stop on match left counter running");
    a_single_rise: assert property (cycle_start && out_en_reg[1] && !match_hit[1]
                                    && match_act_reg[1] != '0 |=> pwm_o[1]) // R05
        else $error("single edge output did not rise at cycle start");
    a_single_fall: assert property (pwm_mode_reg && match_hit[1] |=> !pwm_o[1]) // R04
        else $error("single edge output did not fall at its match");
    a_double_rise: assert property (pwm_mode_reg && out_en_reg[2] && double_reg[2]
                                    && match_hit[1] && !match_hit[2] |=> pwm_o[2]) // R07
        else $error("double edge output did not rise at its match");
    a_release_hold: assert property (pwm_mode_reg && !cycle_start
                                     |=> match_act_reg == $past(match_act_reg)) // R11
        else $error("match value changed outside the cycle boundary");
    a_flag_sticky: assert property (hit_irq[3] ##1 !hit_irq[3] [*2]
                                    |-> irq_status_reg[3] || $past(wr_en)) // R14
        else $error("match flag lost without clear");
    a_timer_quiet: assert property (!pwm_mode_reg |=> pwm_o == '0)           // R12
        else $error("pwm output active in timer mode");

endmodule : multi_channel_match_pwm
`default_nettype wire

// ---- verification/pwm_load_model.sv ----
// External load model: integrates the high time of two PWM outputs
`timescale 1ns/1ps
`default_nettype none

module pwm_load_model (
    input  wire logic       clk_i,
    input  wire logic       clr_i,
    input  wire logic       en_i,
    input  wire logic [6:1] pwm_i,
    output logic [15:0]     hi1_o,
    output logic [15:0]     hi2_o
);
    // High cycles inside the window; the count stays readable after it closes
    always_ff @(posedge clk_i) begin
        if (clr_i) begin
            hi1_o <= 16'h0;
            hi2_o <= 16'h0;
        end else if (en_i) begin
            hi1_o <= hi1_o + {15'h0, pwm_i[1]};
            hi2_o <= hi2_o + {15'h0, pwm_i[2]};
        end
    end
endmodule : pwm_load_model
`default_nettype wire

// ---- verification/multi_channel_match_pwm_tb_top.sv ----
// Random and corner testbench for the match PWM block
`timescale 1ns/1ps
`default_nettype none
`include "pwm_params.svh"

module multi_channel_match_pwm_tb_top
    import pwm_pkg::*;
;
    logic        clk_i, rst_i, en, clr, irq;
    logic [1:0]  cap;
    logic [6:1]  pwm;
    logic [15:0] hi1, hi2;
    logic [31:0] q, q0;
    wb_req_s     req;
    wb_rsp_s     rsp;
    int          failures, tests_run, cycles, seed, p, m1, m2;

    multi_channel_match_pwm i_multi_channel_match_pwm (.clk_i(clk_i), .rst_i(rst_i),
        .wb_req_i(req), .wb_rsp_o(rsp), .cap_i(cap), .pwm_o(pwm), .irq_o(irq));
    pwm_load_model i_pwm_load_model (.clk_i(clk_i), .clr_i(clr), .en_i(en), .pwm_i(pwm),
        .hi1_o(hi1), .hi2_o(hi2));

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // Hang guard; capture pins keep moving so the edge detector is exercised
    always @(posedge clk_i) begin
        cycles++;
        cap <= rst_i ? 2'h0 : cap + 2'h1;
        if (cycles > 20000) begin
            failures++;
            finish_test();
        end
    end

    // Classic single cycle; ack is sampled at the edge, then one idle cycle
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        req <= '{1'b1, 1'b1, we, 4'hf, a, d};
        @(posedge clk_i iff rsp.ack === 1'b1);
        q = rsp.dat;
        req <= '0;
        @(posedge clk_i);
    endtask : wb

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // Double edge high time over four periods; fall before rise wraps round
    function automatic int dbl(input int a, input int b);
        return 4 * (b > a ? b - a : p + 1 - (a - b));
    endfunction : dbl

    // Settle two periods, then measure exactly four whole periods
    task automatic measure(input int e1, input int e2);
        repeat (2 * (p + 1)) @(posedge clk_i);
        clr <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
        en  <= 1'b1;
        repeat (4 * (p + 1)) @(posedge clk_i);
        en <= 1'b0;
        @(posedge clk_i);
        chk("single high", 32'(e1), {16'h0, hi1});
        chk("double high", 32'(e2), {16'h0, hi2});
    endtask : measure

    // Count source rate: two reads taken three cycles apart differ by d
    task automatic rate(input logic [31:0] cc, input logic [31:0] pre, input logic [31:0] d);
        wb(1'b1, `PWM_OFS_CONTROL, 32'h2);
        wb(1'b1, `PWM_OFS_COUNT_CTRL, cc);
        wb(1'b1, `PWM_OFS_PRESCALE, pre);
        wb(1'b1, `PWM_OFS_CONTROL, 32'h1);
        wb(1'b1, `PWM_OFS_COUNT, 32'h100);
        wb(1'b0, `PWM_OFS_COUNT, 32'h0);
        q0 = q;
        wb(1'b0, `PWM_OFS_COUNT, 32'h0);
        chk("count rate", q0 + d, q);
    endtask : rate

    task automatic finish_test();
        $display("Checks run %0d, failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    initial begin
        seed = 80;
        {failures, tests_run} = '0;
        {en, clr} = '0;
        req   = '0;
        rst_i = 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, `PWM_OFS_IRQ_STATUS, 32'h0);
        chk("status reset", 32'h0, q);
        wb(1'b0, 8'hfc, 32'h0);
        chk("unmapped read", 32'h0, q);
        // Outputs 1 and 2 enabled, output 2 double edged
        wb(1'b1, `PWM_OFS_PWM_CTRL, 32'h0000_0604);
        for (int t = 0; t < 6; t++) begin
            p  = 3 + $unsigned($random(seed)) % 7;
            m1 = 1 + $unsigned($random(seed)) % (p - 1);
            m2 = m1 % (p - 1) + 1;
            if (t == 0) begin
                p  = 3;
                m1 = 2;
                m2 = 1;
            end
            wb(1'b1, `PWM_OFS_CONTROL, 32'h2);
            wb(1'b1, `PWM_OFS_MATCH_BASE, 32'(p));
            wb(1'b1, `PWM_OFS_MATCH_BASE + 8'h04, 32'(m1));
            wb(1'b1, `PWM_OFS_MATCH_BASE + 8'h08, 32'(m2));
            wb(1'b1, `PWM_OFS_CONTROL, 32'h9);
            measure(4 * (m1 + 1), dbl(m1, m2));
        end
        // A new period must wait for its release
        wb(1'b1, `PWM_OFS_MATCH_BASE, 32'(p + 2));
        measure(4 * (m1 + 1), dbl(m1, m2));
        wb(1'b1, `PWM_OFS_RELEASE, 32'h1);
        p = p + 2;
        measure(4 * (m1 + 1), dbl(m1, m2));
        // Timer mode: match three stops the count and flags an interrupt
        wb(1'b1, `PWM_OFS_CONTROL, 32'h2);
        wb(1'b1, `PWM_OFS_MATCH_CTRL, 32'h0000_0a00);
        wb(1'b1, `PWM_OFS_MATCH_BASE + 8'h0c, 32'h6);
        wb(1'b1, `PWM_OFS_IRQ_ENABLE, 32'h8);
        wb(1'b1, `PWM_OFS_CONTROL, 32'h1);
        repeat (20) @(posedge clk_i);
        chk("timer outputs", 32'h0, {26'h0, pwm});
        wb(1'b0, `PWM_OFS_COUNT, 32'h0);
        chk("stop count", 32'h6, q);
        chk("irq raised", 32'h1, {31'h0, irq});
        wb(1'b0, `PWM_OFS_IRQ_STATUS, 32'h0);
        chk("status set", 32'h8, q);
        wb(1'b1, `PWM_OFS_IRQ_ENABLE, 32'h0);
        chk("irq masked", 32'h0, {31'h0, irq});
        wb(1'b1, `PWM_OFS_IRQ_CLEAR, 32'h8);
        wb(1'b0, `PWM_OFS_IRQ_STATUS, 32'h0);
        chk("status clear", 32'h0, q);
        // Counter mode: rising edges with prescale, then both and falling edges
        rate(32'h1, 32'h1, 32'h1);
        rate(32'h7, 32'h0, 32'h2);
        rate(32'h6, 32'h0, 32'h1);
        finish_test();
    end
endmodule : multi_channel_match_pwm_tb_top
`default_nettype wire
